// file: acqcr_regs.sv
// Purpose: Control word and decimation rate registers of the acquisition chain
// Assumes: 16-bit internal bus, one-cycle registered read data, one clock
// Notes:   Byte accesses to the control word are not supported
//          Every access is answered one cycle after its strobe, mapped or not
//          Unmapped offsets ignore writes and read as zero
//          Control and ratio outputs lag the stored registers by one cycle
//          Converter strobes pass two sync flops, then an optional delay line
//          Gain adjustment codes are test only; software keeps them at one
//          Mask bits act on the write alone and are never stored
//
// What this block does
// [RQ1] Control bits change only when their mask bit, eight higher, is set.
// [RQ2] Mask bit positions of the control word read as zero.
// [RQ3] Control word is accessed as full 16 bits only; no byte accesses.
// [RQ4] Offsets decode relative to 0x0200 blocking and 0x300 non-blocking.
// [RQ5] Input-short bit set shorts current and voltage converter inputs.
// [RQ6] Bit 6 enables supply pin frequency compensation, allowing a capacitor.
// [RQ7] Bits 5,4,3 choose temp, volt, current gain; one is standard default.
// [RQ8] Software keeps gain select bits at one; adjustment is test only.
// [RQ9] Bits 2,1,0 add about 100 ns input delay per channel.
// [RQ10] Control word at 0x5E; reset sets only gain select bits.
// [RQ11] Codes 001,010,011,101 select ratios 64,128,256,1024.
// [RQ12] Codes 000,100,110,111 select ratio 512 at 1 kHz.
// [RQ13] Two sinc3 stages; first fixed at 8, ratio covers both.
// [RQ14] Rate register at 0x60, resets to code 100.
// [RQ15] Rate register bits 7 to 3 read zero and ignore writes.
`timescale 1ns/1ns
module acqcr_regs (
	input  wire logic        CLK_I,               // System clock, 50 MHz
	input  wire logic        RESET_N_I,           // Sync reset, active low
	input  wire logic        BUS_SEL_I,           // Access strobe, one cycle
	input  wire logic        BUS_WR_I,            // 1 write, 0 read
	input  wire logic [15:0] BUS_ADDR_I,          // Global byte address
	input  wire logic [15:0] BUS_WDATA_I,         // Write data
	input  wire logic        TEMP_SAMPLE_I,       // Temperature converter strobe
	input  wire logic        VOLT_SAMPLE_I,       // Voltage converter strobe
	input  wire logic        CURR_SAMPLE_I,       // Current converter strobe
	output logic [15:0]      BUS_RDATA_O,         // Read data, registered
	output logic             BUS_ACK_O,           // Access done pulse
	output logic             INPUT_SHORT_O,       // Short converter inputs
	output logic             EXT_CAP_COMP_O,      // Supply pin compensation on
	output logic             TEMP_ADC_GAIN_SEL_O, // 1 standard gain
	output logic             VOLT_ADC_GAIN_SEL_O, // 1 standard gain
	output logic             CURR_ADC_GAIN_SEL_O, // 1 standard gain
	output logic             TEMP_SAMPLE_O,       // Temperature strobe after delay
	output logic             VOLT_SAMPLE_O,       // Voltage strobe after delay
	output logic             CURR_SAMPLE_O,       // Current strobe after delay
	output logic [10:0]      DEC_TOTAL_O,         // Combined decimation ratio
	output logic [10:0]      DEC_SECOND_O         // Second stage ratio
);
	acqcr_pkg::acqcr_req_t    req;
	acqcr_pkg::acqcr_analog_t analog;
	acqcr_pkg::acqcr_dec_t    dec;
	logic [7:0]               ctrl_ff;
	logic [7:0]               nxt_ctrl;
	logic [2:0]               rate_ff;
	logic [2:0]               nxt_rate;
	logic [15:0]              rdata_ff;
	logic [15:0]              nxt_rdata;
	logic                     ack_ff;
	logic                     nxt_ack;
	logic [7:0]               offset;
	logic                     in_window;
	logic                     hit_ctrl;
	logic                     hit_rate;
	logic [2:0]               smp_s1_ff;
	logic [2:0]               smp_s2_ff;
	logic [2:0]               smp_dly;
	acqcr_pkg::acqcr_analog_t analog_ff;
	acqcr_pkg::acqcr_dec_t    dec_ff;
	logic [2:0]               smp_out_ff;
	logic [2:0]               nxt_smp_s1;
	logic [2:0]               nxt_smp_s2;
	logic [2:0]               nxt_smp_out;
	acqcr_pkg::acqcr_analog_t nxt_analog;
	acqcr_pkg::acqcr_dec_t    nxt_dec;
	logic                     wr_ctrl;
	logic                     wr_rate;
	logic                     rd_ctrl;
	logic                     rd_rate;

	// Window test: offset valid within either base
	function automatic logic in_base(input logic [15:0] addr, input logic [15:0] base);
		in_base = (addr >= base) && (addr < base + acqcr_pkg::WINDOW_SPAN);
	endfunction

	// Offset match of a live access inside a window
	function automatic logic hit_offset(input logic sel, input logic win,
		input logic [7:0] ofs, input logic [7:0] target);
		hit_offset = sel && win && (ofs == target);
	endfunction

	// Bus request bundle
	assign req.sel   = BUS_SEL_I;
	assign req.wr    = BUS_WR_I;
	assign req.addr  = BUS_ADDR_I;
	assign req.wdata = BUS_WDATA_I;

	// Address decode against both windows
	always_comb begin
		in_window = in_base(req.addr, acqcr_pkg::BASE_BLOCKING)      // [RQ4]
			|| in_base(req.addr, acqcr_pkg::BASE_NONBLOCKING);        // [RQ4]
		offset    = req.addr[7:0];
		// Only the low address byte is the offset; the window test covers the rest
		hit_ctrl  = hit_offset(req.sel, in_window, offset, acqcr_pkg::OFS_CTRL_WORD); // [RQ10]
		hit_rate  = hit_offset(req.sel, in_window, offset, acqcr_pkg::OFS_RATE_SEL);  // [RQ14]
		// Split each hit by direction; reads never touch stored state
		wr_ctrl   = hit_ctrl && req.wr;
		wr_rate   = hit_rate && req.wr;
		rd_ctrl   = hit_ctrl && !req.wr;
		rd_rate   = hit_rate && !req.wr;
	end

	// Control word next value: full word write, mask in the high byte gates each low bit
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			// Unmasked bits keep their old value; byte writes are not decoded
			nxt_ctrl = (ctrl_ff & ~req.wdata[15:8])            // [RQ1] [RQ3]
				| (req.wdata[7:0] & req.wdata[15:8]);           // [RQ1]
		end
	end

	// Control word register; reset leaves only the gain selects set
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			ctrl_ff <= acqcr_pkg::CTRL_RESET; // [RQ10]
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Rate field next value; only the three field bits are stored
	always_comb begin
		nxt_rate = rate_ff;
		if (wr_rate) begin
			nxt_rate = req.wdata[2:0]; // [RQ15]
		end
	end

	// Rate field register; reset selects the 512 code
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			rate_ff <= acqcr_pkg::RATE_RESET; // [RQ14]
		end else begin
			rate_ff <= nxt_rate;
		end
	end

	// Read data: mask bits and unused rate bits read zero, idle bus reads zero
	always_comb begin
		nxt_rdata = 16'h0000;
		if (rd_ctrl) begin
			nxt_rdata = {8'h00, ctrl_ff}; // [RQ2]
		end
		if (rd_rate) begin
			nxt_rdata = {13'h0, rate_ff}; // [RQ15]
		end
	end

	// Read data register; stands for the one answer cycle only
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Every access is answered, mapped or not, so software never stalls
	always_comb begin
		nxt_ack = req.sel;
	end

	// Answer register, loaded on the taking edge, high for the one cycle after it
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			ack_ff <= 1'h0;
		end else begin
			ack_ff <= nxt_ack;
		end
	end

	// Analog control fields out of the control word
	always_comb begin
		analog.input_short       = ctrl_ff[acqcr_pkg::POS_INPUT_SHORT]; // [RQ5]
		analog.ext_cap_comp      = ctrl_ff[acqcr_pkg::POS_EXT_CAP];     // [RQ6]
		analog.temp_adc_gain_sel = ctrl_ff[acqcr_pkg::POS_TEMP_GAIN];   // [RQ7]
		analog.volt_adc_gain_sel = ctrl_ff[acqcr_pkg::POS_VOLT_GAIN];   // [RQ7]
		analog.curr_adc_gain_sel = ctrl_ff[acqcr_pkg::POS_CURR_GAIN];   // [RQ7]
	end

	// Decimation ratio decode
	acqcr_rate_map i_acqcr_rate_map (
		.rate_select_field_i (rate_ff),
		.dec_o               (dec)
	);

	// Converter strobes come from the analog side: two-stage sync
	always_comb begin
		// Asynchronous pins; the first stage may go metastable
		nxt_smp_s1 = {TEMP_SAMPLE_I, VOLT_SAMPLE_I, CURR_SAMPLE_I};
		nxt_smp_s2 = smp_s1_ff;
	end

	// Synchroniser flops; only the second stage feeds any logic
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			smp_s1_ff <= 3'h0;
			smp_s2_ff <= 3'h0;
		end else begin
			smp_s1_ff <= nxt_smp_s1;
			smp_s2_ff <= nxt_smp_s2;
		end
	end

	// Per-channel optional input delay
	acqcr_delay_line i_acqcr_delay_line_temp (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (ctrl_ff[acqcr_pkg::POS_TEMP_DELAY]), // [RQ9]
		.sample_i  (smp_s2_ff[2]),
		.sample_o  (smp_dly[2])
	);

	// Voltage channel
	acqcr_delay_line i_acqcr_delay_line_volt (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (ctrl_ff[acqcr_pkg::POS_VOLT_DELAY]), // [RQ9]
		.sample_i  (smp_s2_ff[1]),
		.sample_o  (smp_dly[1])
	);

	// Current channel
	acqcr_delay_line i_acqcr_delay_line_curr (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.enable_i  (ctrl_ff[acqcr_pkg::POS_CURR_DELAY]), // [RQ9]
		.sample_i  (smp_s2_ff[0]),
		.sample_o  (smp_dly[0])
	);

	// Analog control next value, straight from the stored word
	always_comb begin
		nxt_analog = analog;
	end

	// Analog control output flops; the pins see no decode glitches
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			analog_ff <= '0;
		end else begin
			analog_ff <= nxt_analog;
		end
	end

	// Ratio next value from the rate decode
	always_comb begin
		nxt_dec = dec;
	end

	// Ratio output flops; ratios follow the rate field one cycle later
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			dec_ff <= '0;
		end else begin
			dec_ff <= nxt_dec;
		end
	end

	// Strobe next value after the optional delay
	always_comb begin
		nxt_smp_out = smp_dly;
	end

	// Strobe output flops
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			smp_out_ff <= 3'h0;
		end else begin
			smp_out_ff <= nxt_smp_out;
		end
	end

	// Port drive
	assign BUS_RDATA_O         = rdata_ff;
	assign BUS_ACK_O           = ack_ff;

	// Analog control pins
	assign INPUT_SHORT_O       = analog_ff.input_short;
	assign EXT_CAP_COMP_O      = analog_ff.ext_cap_comp;
	assign TEMP_ADC_GAIN_SEL_O = analog_ff.temp_adc_gain_sel;
	assign VOLT_ADC_GAIN_SEL_O = analog_ff.volt_adc_gain_sel;
	assign CURR_ADC_GAIN_SEL_O = analog_ff.curr_adc_gain_sel;

	// Converter strobe pins
	assign TEMP_SAMPLE_O       = smp_out_ff[2];
	assign VOLT_SAMPLE_O       = smp_out_ff[1];
	assign CURR_SAMPLE_O       = smp_out_ff[0];

	// Decimation ratio pins
	assign DEC_TOTAL_O         = dec_ff.total_ratio;
	assign DEC_SECOND_O        = dec_ff.second_ratio;
endmodule

// file: acqcr_pkg.sv
// Purpose: Shared constants and types for the acquisition chain control registers
// Assumes: 16-bit internal register bus, offsets relative to two window bases
// Notes:   Every number used by the design files is named here once
package acqcr_pkg;
	// Address windows and register offsets
	localparam logic [15:0] BASE_BLOCKING    = 16'h0200;
	localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
	localparam logic [15:0] WINDOW_SPAN      = 16'h0100;
	localparam logic [7:0]  OFS_CTRL_WORD    = 8'h5E;
	localparam logic [7:0]  OFS_RATE_SEL     = 8'h60;

	// Control word field positions (low byte); mask sits eight above
	localparam int unsigned MASK_SHIFT       = 8;
	localparam int unsigned POS_INPUT_SHORT  = 7;
	localparam int unsigned POS_EXT_CAP      = 6;
	localparam int unsigned POS_TEMP_GAIN    = 5;
	localparam int unsigned POS_VOLT_GAIN    = 4;
	localparam int unsigned POS_CURR_GAIN    = 3;
	localparam int unsigned POS_TEMP_DELAY   = 2;
	localparam int unsigned POS_VOLT_DELAY   = 1;
	localparam int unsigned POS_CURR_DELAY   = 0;

	// Reset values
	localparam logic [7:0]  CTRL_RESET       = 8'h38;
	localparam logic [2:0]  RATE_RESET       = 3'h4;

	// Rate select codes
	localparam logic [2:0]  RATE_CODE_64     = 3'h1;
	localparam logic [2:0]  RATE_CODE_128    = 3'h2;
	localparam logic [2:0]  RATE_CODE_256    = 3'h3;
	localparam logic [2:0]  RATE_CODE_1024   = 3'h5;

	// Decimation ratios and first stage
	localparam logic [10:0] RATIO_64         = 11'h040;
	localparam logic [10:0] RATIO_128        = 11'h080;
	localparam logic [10:0] RATIO_256        = 11'h100;
	localparam logic [10:0] RATIO_512        = 11'h200;
	localparam logic [10:0] RATIO_1024       = 11'h400;
	localparam logic [10:0] FIRST_STAGE      = 11'h008;

	// Input delay time and clock
	localparam int unsigned DELAY_NS         = 100;
	localparam int unsigned CLK_PERIOD_NS    = 20;
	localparam int unsigned DELAY_CYCLES     = DELAY_NS / CLK_PERIOD_NS;

	// Register bus request
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} acqcr_req_t;

	// Analog controls
	typedef struct packed {
		logic input_short;
		logic ext_cap_comp;
		logic temp_adc_gain_sel;
		logic volt_adc_gain_sel;
		logic curr_adc_gain_sel;
	} acqcr_analog_t;

	// Decimation setup
	typedef struct packed {
		logic [10:0] total_ratio;
		logic [10:0] second_ratio;
	} acqcr_dec_t;
endpackage

// file: acqcr_rate_map.sv
// Purpose: Maps the rate select field to decimation ratios of two sinc3 stages
// Assumes: First stage fixed at eight
// Notes:   Pure combinational decode
`timescale 1ns/1ns
module acqcr_rate_map (
	input  wire logic [2:0]          rate_select_field_i, // Field code
	output acqcr_pkg::acqcr_dec_t    dec_o                // Ratios
);
	// Decode code to combined ratio; unlisted codes give 512
	always_comb begin
		dec_o = '0;
		case (rate_select_field_i)
			acqcr_pkg::RATE_CODE_64:   dec_o.total_ratio = acqcr_pkg::RATIO_64;   // [RQ11]
			acqcr_pkg::RATE_CODE_128:  dec_o.total_ratio = acqcr_pkg::RATIO_128;  // [RQ11]
			acqcr_pkg::RATE_CODE_256:  dec_o.total_ratio = acqcr_pkg::RATIO_256;  // [RQ11]
			acqcr_pkg::RATE_CODE_1024: dec_o.total_ratio = acqcr_pkg::RATIO_1024; // [RQ11]
			default:                   dec_o.total_ratio = acqcr_pkg::RATIO_512;  // [RQ12]
		endcase
		// Second stage takes the rest after the fixed first stage
		dec_o.second_ratio = dec_o.total_ratio / acqcr_pkg::FIRST_STAGE; // [RQ13]
	end
endmodule

// file: acqcr_delay_line.sv
// Purpose: Delays a channel clock by a fixed count of system clocks when enabled
// Assumes: Delay time rounds down to whole cycles, at least two
// Notes:   Output registered; bypass when disabled
`timescale 1ns/1ns
module acqcr_delay_line (
	input  wire logic clk_i,      // System clock
	input  wire logic reset_n_i,  // Sync reset, active low
	input  wire logic enable_i,   // Add delay
	input  wire logic sample_i,   // Synchronised channel strobe
	output logic      sample_o    // Possibly delayed strobe
);
	logic [acqcr_pkg::DELAY_CYCLES-1:0] pipe_ff;
	logic [acqcr_pkg::DELAY_CYCLES-1:0] nxt_pipe;
	logic                               out_ff;
	logic                               nxt_out;

	// Shift line and select output
	always_comb begin
		nxt_pipe = {pipe_ff[acqcr_pkg::DELAY_CYCLES-2:0], sample_i};
		nxt_out  = enable_i ? pipe_ff[acqcr_pkg::DELAY_CYCLES-1] : sample_i; // [RQ9]
	end

	// Register stage
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pipe_ff <= '0;
			out_ff  <= 1'b0;
		end else begin
			pipe_ff <= nxt_pipe;
			out_ff  <= nxt_out;
		end
	end

	assign sample_o = out_ff;
endmodule

// file: acqcr_regs_checker.sv
// Purpose: Concurrent checks on the control and rate register ports
// Assumes: One clock, synchronous active-low reset, answer one cycle after the strobe
// Notes:   Attached to the top module by the bind at the foot
`timescale 1ns/1ns
module acqcr_regs_checker (
	input wire logic        CLK_I,               // System clock
	input wire logic        RESET_N_I,           // Sync reset, active low
	input wire logic        BUS_SEL_I,           // Access strobe
	input wire logic        BUS_WR_I,            // Write flag
	input wire logic [15:0] BUS_ADDR_I,          // Global address
	input wire logic [15:0] BUS_WDATA_I,         // Write data
	input wire logic [15:0] BUS_RDATA_O,         // Read data
	input wire logic        BUS_ACK_O,           // Access done
	input wire logic        INPUT_SHORT_O,       // Input short
	input wire logic        EXT_CAP_COMP_O,      // Compensation on
	input wire logic        TEMP_ADC_GAIN_SEL_O, // Temperature gain
	input wire logic [10:0] DEC_TOTAL_O,         // Combined ratio
	input wire logic [10:0] DEC_SECOND_O         // Second stage ratio
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// Expected combined ratio of a field code
	function automatic logic [10:0] ratio_of(input logic [2:0] c);
		return (c == 3'h5) ? 11'h400 : (c inside {3'h1, 3'h2, 3'h3}) ? (11'h020 << c) : 11'h200;
	endfunction

	// Writes to either window
	sequence s_ctrl_wr;
		BUS_SEL_I && BUS_WR_I && BUS_ADDR_I[7:0] == 8'h5E && BUS_ADDR_I[15:9] == 7'h01;
	endsequence
	sequence s_rate_wr;
		BUS_SEL_I && BUS_WR_I && BUS_ADDR_I[7:0] == 8'h60 && BUS_ADDR_I[15:9] == 7'h01;
	endsequence

	// Bus answer, read data and control outputs
	property p_ack; BUS_SEL_I |=> BUS_ACK_O; endproperty
	property p_no_ack; !BUS_SEL_I |=> !BUS_ACK_O; endproperty
	property p_rdata_idle; !BUS_ACK_O |-> BUS_RDATA_O == 16'h0000; endproperty
	property p_mask_read; BUS_ACK_O |-> BUS_RDATA_O[15:8] == 8'h00; endproperty
	property p_short;
		s_ctrl_wr ##0 BUS_WDATA_I[15] |=> ##1 INPUT_SHORT_O == $past(BUS_WDATA_I[7], 2);
	endproperty
	property p_ext_cap_comp_hold; s_ctrl_wr ##0 !BUS_WDATA_I[14] |=> ##1 $stable(EXT_CAP_COMP_O); endproperty
	property p_gain;
		s_ctrl_wr ##0 BUS_WDATA_I[13] |=> ##1 TEMP_ADC_GAIN_SEL_O == $past(BUS_WDATA_I[5], 2);
	endproperty
	property p_rate; s_rate_wr |=> ##1 DEC_TOTAL_O == ratio_of($past(BUS_WDATA_I[2:0], 2)); endproperty
	property p_stages; DEC_TOTAL_O == (DEC_SECOND_O << 3); endproperty

	a_ack: assert property (p_ack) else $error("no answer to an access");
	a_no_ack: assert property (p_no_ack) else $error("answer without access");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	a_mask_read: assert property (p_mask_read) else $error("upper byte not zero");
	a_short: assert property (p_short) else $error("input short not written");
	a_ext_cap_comp_hold: assert property (p_ext_cap_comp_hold) else $error("masked bit changed");
	a_gain: assert property (p_gain) else $error("gain select not written");
	a_rate: assert property (p_rate) else $error("wrong combined ratio");
	a_stages: assert property (p_stages) else $error("first stage not eight");
endmodule

bind acqcr_regs acqcr_regs_checker i_acqcr_regs_checker (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
	.BUS_SEL_I(BUS_SEL_I), .BUS_WR_I(BUS_WR_I), .BUS_ADDR_I(BUS_ADDR_I),
	.BUS_WDATA_I(BUS_WDATA_I), .BUS_RDATA_O(BUS_RDATA_O), .BUS_ACK_O(BUS_ACK_O),
	.INPUT_SHORT_O(INPUT_SHORT_O), .EXT_CAP_COMP_O(EXT_CAP_COMP_O),
	.TEMP_ADC_GAIN_SEL_O(TEMP_ADC_GAIN_SEL_O), .DEC_TOTAL_O(DEC_TOTAL_O),
	.DEC_SECOND_O(DEC_SECOND_O));

// file: acqcr_regs_tb.sv
// Purpose: Self-checking bench for the control and rate registers
// Assumes: Strobe taken on a rising edge, answer visible just after it
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module acqcr_regs_tb;
	logic        clk_i = 1'h0;
	logic        rst_n = 1'h0;
	logic        sel   = 1'h0;
	logic        wr    = 1'h0;
	logic [15:0] addr  = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [2:0]  samp  = 3'h0;
	logic [15:0] rdata;
	logic        ack;
	logic        short_o;
	logic        ext_cap_comp_o;
	logic [2:0]  gain;
	logic [2:0]  sout;
	logic [10:0] dec_total;
	logic [10:0] dec_second;
	int          err_total = 0;
	int          tests_run = 0;

	// Clock of 20 ns
	always #10 clk_i = ~clk_i;

	acqcr_regs i_acqcr_regs (.CLK_I(clk_i), .RESET_N_I(rst_n), .BUS_SEL_I(sel), .BUS_WR_I(wr),
		.BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .TEMP_SAMPLE_I(samp[2]),
		.VOLT_SAMPLE_I(samp[1]), .CURR_SAMPLE_I(samp[0]), .BUS_RDATA_O(rdata),
		.BUS_ACK_O(ack), .INPUT_SHORT_O(short_o), .EXT_CAP_COMP_O(ext_cap_comp_o),
		.TEMP_ADC_GAIN_SEL_O(gain[2]), .VOLT_ADC_GAIN_SEL_O(gain[1]),
		.CURR_ADC_GAIN_SEL_O(gain[0]), .TEMP_SAMPLE_O(sout[2]), .VOLT_SAMPLE_O(sout[1]),
		.CURR_SAMPLE_O(sout[0]), .DEC_TOTAL_O(dec_total), .DEC_SECOND_O(dec_second));

	// Counts and verdict
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One access, strobe held up to the taking edge, then one idle cycle
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q);
		sel = 1'h1;
		wr = w;
		addr = a;
		wdata = d;
		@(posedge clk_i);
		#1;
		`CHK("ack", 1'h1, ack)
		q = rdata;
		sel = 1'h0;
		@(posedge clk_i);
		#1;
		`CHK("ack_end", 1'h0, ack)
	endtask
	task automatic wt(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'h1, a, d, q);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] q;
		bus(1'h0, a, 16'h0000, q);
		`CHK("rdata", e, q)
	endtask

	// Reset values
	task automatic t_reset;
		rd_chk(16'h025E, 16'h0038);
		rd_chk(16'h0260, 16'h0004);
		`CHK("gain", 3'h7, gain)
		`CHK("total", 11'h200, dec_total)
	endtask

	// Write masks and control outputs
	task automatic t_mask;
		wt(16'h025E, 16'h00FF);
		rd_chk(16'h025E, 16'h0038);
		wt(16'h035E, 16'hFF00);
		rd_chk(16'h035E, 16'h0000);
		`CHK("outs", 5'h00, {short_o, ext_cap_comp_o, gain})
		wt(16'h025E, 16'h80C0);
		rd_chk(16'h025E, 16'h0080);
		`CHK("short", 1'h1, short_o)
		`CHK("ext_cap_comp", 1'h0, ext_cap_comp_o)
		wt(16'h025E, 16'h7878);
		rd_chk(16'h025E, 16'h00F8);
		`CHK("outs", 5'h1F, {short_o, ext_cap_comp_o, gain})
		wt(16'h025E, 16'h8000);
		`CHK("short", 1'h0, short_o)
		rd_chk(16'h025E, 16'h0078);
		`CHK("short", 1'h0, short_o)
	endtask

	// Unmapped offset and address outside both windows
	task automatic t_unmapped;
		wt(16'h0250, 16'hFFFF);
		rd_chk(16'h0250, 16'h0000);
		wt(16'h045E, 16'hFF00);
		rd_chk(16'h025E, 16'h0078);
	endtask

	// Every rate code, upper bits written as ones
	task automatic t_rate;
		logic [10:0] tbl [8] = '{11'h200, 11'h040, 11'h080, 11'h100,
			11'h200, 11'h400, 11'h200, 11'h200};
		for (int i = 0; i < 8; i++) begin
			wt(16'h0360, {13'h1FFF, i[2:0]});
			rd_chk(16'h0260, {13'h0, i[2:0]});
			`CHK("total", tbl[i], dec_total)
			`CHK("second", tbl[i] >> 3, dec_second)
		end
	endtask

	// Strobe latency with and without the extra delay
	task automatic lat(input int i, input logic en, input int e);
		int n;
		wt(16'h025E, {8'h01 << i, en ? (8'h01 << i) : 8'h00});
		n = 0;
		samp[i] = 1'h1;
		while (sout[i] !== 1'h1 && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		`CHK("latency", e, n)
		samp[i] = 1'h0;
		repeat (12) @(posedge clk_i);
		#1;
	endtask

	// Watchdog
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rst_n = 1'h1;
		t_reset();
		t_mask();
		t_unmapped();
		t_rate();
		for (int i = 0; i < 3; i++) begin
			lat(i, 1'h0, 4);
			lat(i, 1'h1, 9);
		end
		wrap_up();
	end
endmodule
